// >>> src/adc_ctrl_regs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define DIV_CTRL_ADDR    8'h70
`define PWR_CTRL_ADDR    8'h71
`define DLL_CTRL_ADDR    8'h72
`define OUT_FMT_ADDR     8'h73
`define STATUS_ADDR      8'h76

`define OVR_EN_BIT       7
`define SEL_MSB          1
`define SEL_LSB          0
`define DLL_SLOW_BIT     0
`define FMT_MSB          1
`define FMT_LSB          0
`define CMOS_BIT         4
`define LOW_DRIVE_BIT    5

`define ST_CAL_DONE_BIT  0
`define ST_LOCK_BIT      1
`define ST_DIV_LSB       2
`define ST_PWR_LSB       4

`define DIV_CTRL_RST     8'h00
`define PWR_CTRL_RST     8'h00
`define DLL_CTRL_RST     8'h00
`define OUT_FMT_RST      8'h00

`define CAL_PATTERN      16'hCCCC
`define CAL_TIME_MS      200
`define DLL_RELOCK_US    52
`define DLL_REF_MSPS     250
`define SLOW_MIN_MSPS    40
`define SLOW_MAX_MSPS    100
`define FAST_MIN_MSPS    80
`define MAX_MSPS         250
`define LATENCY_CYCLES   10

`endif

// >>> src/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;

  typedef enum logic [1:0] {LEVEL_LOW, LEVEL_FLOAT, LEVEL_HIGH} level_e;
  typedef enum logic [1:0] {DIV_BY_1, DIV_BY_2, DIV_BY_4} ratio_e;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLEEP, PWR_NAP} power_e;
  typedef enum logic [1:0] {FMT_TWOS, FMT_GRAY, FMT_OFFSET} format_e;

endpackage : adc_ctrl_pkg

// >>> src/sample_delay_line.sv
// Fixed-depth sample pipeline with registered read data
`timescale 1ns/100ps
module sample_delay_line #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 9
) (
  input  logic             ref_clk,
  input  logic             reset_n,
  input  logic             shift_en,
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stages;
  } line_s;

  line_s st_reg;
  line_s st_next;

  generate
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad
      $error("sample_delay_line needs DEPTH and WIDTH of at least one");
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    if (shift_en) begin
      st_next.stages[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
        st_next.stages[i] = st_reg.stages[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.stages[DEPTH-1];

endmodule : sample_delay_line

// >>> src/adc_clock_power_output_format.sv
// Clock division, DLL lock, power state and output formatting control
// Notes on behaviour
// - Pin low divides by two, floating by one, high by four.
// - Divide by two or four lets a phase slip realign converters.
// - A software divider setting overrides the divider pin.
// - DLL relocks after a rate change; time scales inversely with rate.
// - DLL slow range covers 40 to 100, fast 80 to max.
// - Samples leave as DDR bus, LVDS by default or CMOS.
// - LVDS drive current 3mA by default, 2mA selectable.
// - Output signalling mode chosen by a write to 0x73.
// - Power pin low gives normal, floating sleep, high nap.
// - A software power state overrides the power pin.
// - Nap or sleep releases data, clock and over-range outputs.
// - Clock stopped in nap forces a DLL relock on wake.
// - Format is two's complement by default, Gray or offset via 0x73.
// - Offset binary maps negative full scale to zeros, positive to ones.
// - Two's complement is offset binary with the MSB inverted.
// - Gray keeps the MSB; lower bits XOR with next higher bit.
// - Samples appear ten sample clocks after conversion starts.
// - Calibration drives the fixed pattern 0xCCCC on data outputs.
// - Divide two or four holds output clock low during cal reset.
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"
module adc_clock_power_output_format
  import adc_ctrl_pkg::*;
#(
  parameter int DATA_W         = 14,
  parameter int CLK_MHZ        = 50,
  parameter int LATENCY        = `LATENCY_CYCLES,
  parameter int CAL_CYCLES     = `CAL_TIME_MS * 1000 * CLK_MHZ,
  parameter int RELOCK_SAMPLES = `DLL_RELOCK_US * `DLL_REF_MSPS
) (
  input  logic              ref_clk,
  input  logic              reset_n,
  input  logic [7:0]        addr,
  input  logic [7:0]        wr_data,
  input  logic              wr_en,
  input  logic              rd_en,
  output logic [7:0]        rd_data,
  input  logic [1:0]        clock_ratio_select_pin,
  input  logic [1:0]        power_state_select_pin,
  input  logic              calibration_reset_n,
  input  logic              divider_sync_reset,
  input  logic              phase_slip,
  input  logic              clock_was_stopped,
  input  logic [DATA_W-1:0] sample_a_in,
  input  logic [DATA_W-1:0] sample_b_in,
  input  logic              over_range_a_in,
  input  logic              over_range_b_in,
  output logic [DATA_W-1:0] data_a_out,
  output logic [DATA_W-1:0] data_b_out,
  output logic              over_range_a_out,
  output logic              over_range_b_out,
  output logic              output_sample_clock,
  output logic              outputs_oe,
  output logic              cmos_mode,
  output logic              low_drive_current,
  output logic              dll_slow_range,
  output logic              dll_locked,
  output logic              calibrating
);

  localparam int LINE_W = 2 * DATA_W + 2;
  localparam int CAL_W = 24;
  localparam int RELOCK_W = 16;
  localparam logic [15:0] CAL_WORD = `CAL_PATTERN;

  generate
    if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
      $error("DATA_W must lie between 2 and 16");
    end
    if (LATENCY < 2) begin : g_bad_latency
      $error("LATENCY must be at least two sample clocks");
    end
    if (CAL_CYCLES < 1 || CAL_CYCLES > (1 << CAL_W)) begin : g_bad_cal
      $error("CAL_CYCLES does not fit the calibration counter");
    end
    if (RELOCK_SAMPLES < 1 || RELOCK_SAMPLES >= (1 << RELOCK_W)) begin : g_bad_rl
      $error("RELOCK_SAMPLES does not fit the relock counter");
    end
  endgenerate

  typedef struct packed {
    logic [7:0]          div_ctrl;
    logic [7:0]          pwr_ctrl;
    logic [7:0]          dll_ctrl;
    logic [7:0]          out_fmt;
    logic [7:0]          rd_data;
    logic [1:0]          div_cnt;
    ratio_e              eff_div;
    logic                prev_slow;
    power_e              prev_pwr;
    logic                stop_seen;
    logic [RELOCK_W-1:0] relock_cnt;
    logic                locked;
    logic [CAL_W-1:0]    cal_cnt;
    logic                cal_busy;
    logic [DATA_W-1:0]   data_a;
    logic [DATA_W-1:0]   data_b;
    logic                or_a;
    logic                or_b;
    logic                clk_out;
    logic                oe;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic [LINE_W-1:0] line_q;
  logic              tick;
  ratio_e            ratio;
  power_e            power;

  // Divider pin map; the unused fourth code reads as floating
  function automatic ratio_e ratio_from_pin(input logic [1:0] code);
    unique case (code)
      LEVEL_LOW:  ratio_from_pin = DIV_BY_2;
      LEVEL_HIGH: ratio_from_pin = DIV_BY_4;
      default:    ratio_from_pin = DIV_BY_1;
    endcase
  endfunction : ratio_from_pin

  function automatic ratio_e ratio_from_reg(input logic [1:0] code);
    unique case (code)
      2'h1:    ratio_from_reg = DIV_BY_2;
      2'h2:    ratio_from_reg = DIV_BY_4;
      default: ratio_from_reg = DIV_BY_1;
    endcase
  endfunction : ratio_from_reg

  // Power pin map; the unused fourth code reads as floating
  function automatic power_e power_from_pin(input logic [1:0] code);
    unique case (code)
      LEVEL_LOW:  power_from_pin = PWR_NORMAL;
      LEVEL_HIGH: power_from_pin = PWR_NAP;
      default:    power_from_pin = PWR_SLEEP;
    endcase
  endfunction : power_from_pin

  function automatic power_e power_from_reg(input logic [1:0] code);
    unique case (code)
      2'h1:    power_from_reg = PWR_SLEEP;
      2'h2:    power_from_reg = PWR_NAP;
      default: power_from_reg = PWR_NORMAL;
    endcase
  endfunction : power_from_reg

  function automatic logic [1:0] div_limit(input ratio_e r);
    unique case (r)
      DIV_BY_2: div_limit = 2'h1;
      DIV_BY_4: div_limit = 2'h3;
      default:  div_limit = 2'h0;
    endcase
  endfunction : div_limit

  function automatic int rate_msps(input ratio_e r);
    unique case (r)
      DIV_BY_2: rate_msps = CLK_MHZ / 2;
      DIV_BY_4: rate_msps = CLK_MHZ / 4;
      default:  rate_msps = CLK_MHZ;
    endcase
  endfunction : rate_msps

  function automatic logic range_ok(input logic slow, input ratio_e r);
    int m;
    m = rate_msps(r);
    if (slow) begin
      range_ok = (m >= `SLOW_MIN_MSPS) && (m <= `SLOW_MAX_MSPS);
    end else begin
      range_ok = (m >= `FAST_MIN_MSPS) && (m <= `MAX_MSPS);
    end
  endfunction : range_ok

  // Input samples arrive as offset binary
  function automatic logic [DATA_W-1:0] encode(
    input logic [DATA_W-1:0] ob,
    input logic [1:0]        fmt
  );
    unique case (fmt)
      FMT_OFFSET: encode = ob;
      FMT_GRAY:   encode = ob ^ (ob >> 1);
      default:    encode = {~ob[DATA_W-1], ob[DATA_W-2:0]};
    endcase
  endfunction : encode

  // Conversion latency is split between the line and the output flop
  sample_delay_line #(
    .WIDTH (LINE_W),
    .DEPTH (LATENCY - 1)
  ) u_line (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .shift_en (tick),
    .din      ({over_range_b_in, over_range_a_in, sample_b_in, sample_a_in}),
    .dout     (line_q)
  );

  always_comb begin
    logic             ratio_change;
    logic             slow;
    logic             wake_relock;
    logic [DATA_W-1:0] enc_a;
    logic [DATA_W-1:0] enc_b;
    ratio_change = 1'b0;
    slow = 1'b0;
    wake_relock = 1'b0;
    enc_a = '0;
    enc_b = '0;
    st_next = st_reg;

    // Register writes
    if (wr_en) begin
      unique case (addr)
        `DIV_CTRL_ADDR: st_next.div_ctrl = wr_data;
        `PWR_CTRL_ADDR: st_next.pwr_ctrl = wr_data;
        `DLL_CTRL_ADDR: st_next.dll_ctrl = wr_data;
        `OUT_FMT_ADDR:  st_next.out_fmt = wr_data;
        default: ;
      endcase
    end

    // Read data stand for one cycle only
    st_next.rd_data = 8'h00;
    if (rd_en) begin
      unique case (addr)
        `DIV_CTRL_ADDR: st_next.rd_data = st_reg.div_ctrl;
        `PWR_CTRL_ADDR: st_next.rd_data = st_reg.pwr_ctrl;
        `DLL_CTRL_ADDR: st_next.rd_data = st_reg.dll_ctrl;
        `OUT_FMT_ADDR:  st_next.rd_data = st_reg.out_fmt;
        `STATUS_ADDR: begin
          st_next.rd_data[`ST_CAL_DONE_BIT] = ~st_reg.cal_busy;
          st_next.rd_data[`ST_LOCK_BIT] = st_reg.locked;
          st_next.rd_data[`ST_DIV_LSB +: 2] = st_reg.eff_div;
          st_next.rd_data[`ST_PWR_LSB +: 2] = power;
        end
        default: st_next.rd_data = 8'h00;
      endcase
    end

    // Divider: sync reset and ratio change restart the phase
    ratio_change = (ratio != st_reg.eff_div);
    st_next.eff_div = ratio;
    if (divider_sync_reset || ratio_change) begin
      st_next.div_cnt = 2'h0;
    end else if (phase_slip && ratio != DIV_BY_1) begin
      st_next.div_cnt = st_reg.div_cnt;
    end else if (tick) begin
      st_next.div_cnt = 2'h0;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 2'h1;
    end

    // DLL lock tracking counted in sample clocks
    slow = st_reg.dll_ctrl[`DLL_SLOW_BIT];
    st_next.prev_slow = slow;
    st_next.prev_pwr = power;
    if (st_reg.prev_pwr == PWR_NAP && clock_was_stopped) begin
      st_next.stop_seen = 1'b1;
    end
    wake_relock = (st_reg.prev_pwr == PWR_NAP) && (power != PWR_NAP)
                  && (st_reg.stop_seen || clock_was_stopped);
    if (power != PWR_NAP) begin
      st_next.stop_seen = 1'b0;
    end
    if (ratio_change || slow != st_reg.prev_slow || wake_relock) begin
      st_next.relock_cnt = RELOCK_W'(RELOCK_SAMPLES);
      st_next.locked = 1'b0;
    end else if (st_reg.relock_cnt != '0) begin
      if (tick) begin
        st_next.relock_cnt = st_reg.relock_cnt - 1'b1;
      end
      st_next.locked = 1'b0;
    end else begin
      st_next.locked = range_ok(slow, ratio);
    end

    // Calibration runs while the pin is low and for a fixed time after
    if (!calibration_reset_n) begin
      st_next.cal_busy = 1'b1;
      st_next.cal_cnt = '0;
    end else if (st_reg.cal_busy) begin
      if (st_reg.cal_cnt == CAL_W'(CAL_CYCLES - 1)) begin
        st_next.cal_busy = 1'b0;
      end else begin
        st_next.cal_cnt = st_reg.cal_cnt + 1'b1;
      end
    end

    // Both channels share one format setting
    enc_a = encode(line_q[DATA_W-1:0], st_reg.out_fmt[`FMT_MSB:`FMT_LSB]);
    enc_b = encode(line_q[2*DATA_W-1:DATA_W],
                   st_reg.out_fmt[`FMT_MSB:`FMT_LSB]);

    // Data change on every sample, giving the DDR bus; the clock does too unless cal reset holds it low at divide two or four
    if (tick) begin
      if (st_reg.cal_busy) begin
        st_next.data_a = CAL_WORD[DATA_W-1:0];
        st_next.data_b = CAL_WORD[DATA_W-1:0];
        st_next.or_a = 1'b0;
        st_next.or_b = 1'b0;
      end else begin
        st_next.data_a = enc_a;
        st_next.data_b = enc_b;
        st_next.or_a = line_q[2*DATA_W];
        st_next.or_b = line_q[2*DATA_W+1];
      end
    end

    if (ratio != DIV_BY_1 && !calibration_reset_n) begin
      st_next.clk_out = 1'b0;
    end else if (tick) begin
      st_next.clk_out = ~st_reg.clk_out;
    end

    // Host keeps the clock running here, so the state is safe to hold
    st_next.oe = (power == PWR_NORMAL);
  end

  // Software overrides win over the three-level straps
  assign ratio = st_reg.div_ctrl[`OVR_EN_BIT]
                 ? ratio_from_reg(st_reg.div_ctrl[`SEL_MSB:`SEL_LSB])
                 : ratio_from_pin(clock_ratio_select_pin);
  assign power = st_reg.pwr_ctrl[`OVR_EN_BIT]
                 ? power_from_reg(st_reg.pwr_ctrl[`SEL_MSB:`SEL_LSB])
                 : power_from_pin(power_state_select_pin);

  // A slip only stalls the count, so a tick waits one more input clock
  assign tick = (st_reg.div_cnt == div_limit(st_reg.eff_div))
                && !(phase_slip && st_reg.eff_div != DIV_BY_1)
                && (ratio == st_reg.eff_div) && !divider_sync_reset;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.div_ctrl <= `DIV_CTRL_RST;
      st_reg.pwr_ctrl <= `PWR_CTRL_RST;
      st_reg.dll_ctrl <= `DLL_CTRL_RST;
      st_reg.out_fmt <= `OUT_FMT_RST;
      st_reg.eff_div <= DIV_BY_1;
      st_reg.prev_pwr <= PWR_NORMAL;
      st_reg.relock_cnt <= RELOCK_W'(RELOCK_SAMPLES);
      st_reg.cal_busy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign data_a_out = st_reg.data_a;
  assign data_b_out = st_reg.data_b;
  assign over_range_a_out = st_reg.or_a;
  assign over_range_b_out = st_reg.or_b;
  assign output_sample_clock = st_reg.clk_out;
  assign outputs_oe = st_reg.oe;
  assign cmos_mode = st_reg.out_fmt[`CMOS_BIT];
  assign low_drive_current = st_reg.out_fmt[`LOW_DRIVE_BIT];
  assign dll_slow_range = st_reg.dll_ctrl[`DLL_SLOW_BIT];
  assign dll_locked = st_reg.locked;
  assign calibrating = st_reg.cal_busy;

endmodule : adc_clock_power_output_format

// >>> verification/adc_ctrl_monitor.sv
// Port checker for the converter control block
`timescale 1ns/100ps
module adc_ctrl_monitor #(
  parameter int DATA_W = 14
) (
  input logic              ref_clk,
  input logic              reset_n,
  input logic [7:0]        addr,
  input logic [7:0]        wr_data,
  input logic              wr_en,
  input logic              rd_en,
  input logic [7:0]        rd_data,
  input logic [1:0]        clock_ratio_select_pin,
  input logic [1:0]        power_state_select_pin,
  input logic              calibration_reset_n,
  input logic [DATA_W-1:0] data_a_out,
  input logic [DATA_W-1:0] data_b_out,
  input logic              over_range_a_out,
  input logic              output_sample_clock,
  input logic              outputs_oe,
  input logic              cmos_mode,
  input logic              dll_slow_range,
  input logic              dll_locked,
  input logic              calibrating
);
  // Shadow of the override registers, so pin and software agree
  logic [7:0] div_reg, pwr_reg;
  logic       div1_eff, div4_eff, normal_eff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 8'h00;
      pwr_reg <= 8'h00;
    end else if (wr_en && addr == 8'h70) begin
      div_reg <= wr_data;
    end else if (wr_en && addr == 8'h71) begin
      pwr_reg <= wr_data;
    end
  end
  assign div1_eff = div_reg[7] ? div_reg[1:0] inside {2'd0, 2'd3}
                               : clock_ratio_select_pin[0];
  assign div4_eff = div_reg[7] ? div_reg[1:0] == 2'd2
                               : clock_ratio_select_pin == 2'd2;
  assign normal_eff = pwr_reg[7] ? pwr_reg[1:0] inside {2'd0, 2'd3}
                                 : power_state_select_pin == 2'd0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence low_power_held;
    !normal_eff [*3];
  endsequence
  // Data change only on a tick, up to four clocks after calibration starts
  sequence cal_held;
    calibrating [*6];
  endsequence
  rd_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not idle");
  rd_unmapped_a: assert property (rd_en && !(addr inside {8'h70, 8'h71,
    8'h72, 8'h73, 8'h76}) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  oe_normal_a: assert property (normal_eff [*3] |-> outputs_oe)
    else $error("outputs released in normal state");
  oe_off_a: assert property (low_power_held |-> !outputs_oe)
    else $error("outputs driven in nap or sleep");
  cal_pattern_a: assert property (cal_held |->
    data_a_out == 14'h0CCC && data_b_out == 14'h0CCC && !over_range_a_out)
    else $error("calibration pattern missing");
  clk_hold_a: assert property ((!div1_eff && !calibration_reset_n) [*2]
    |-> !output_sample_clock)
    else $error("output clock not held low");
  lock_range_a: assert property ((!div1_eff || !dll_slow_range) [*3]
    |-> !dll_locked)
    else $error("lock reported out of range");
  relock_drop_a: assert property ($changed({div1_eff, div4_eff})
    |-> ##[1:3] !dll_locked)
    else $error("lock kept over ratio change");
  mode_select_a: assert property (wr_en && addr == 8'h73
    |-> ##2 cmos_mode == $past(wr_data[4], 2))
    else $error("output mode not taken");
endmodule : adc_ctrl_monitor

// >>> verification/capture_receiver_model.sv
// Capture receiver: latches the DDR bus and undoes Gray coding
`timescale 1ns/100ps
module capture_receiver_model (
  input  logic        ref_clk,
  input  logic        output_sample_clock,
  input  logic        outputs_oe,
  input  logic [13:0] data_in,
  output logic [13:0] binary_out
);
  logic        clk_q;
  logic [13:0] gray_q;
  // Latch one sample per output clock edge, both edges
  always @(posedge ref_clk) begin
    clk_q <= output_sample_clock;
    if (outputs_oe && output_sample_clock != clk_q)
      gray_q <= data_in;
  end
  // Decoding from the top keeps each bit tied to the one above
  always_comb begin
    logic b;
    b = gray_q[13];
    binary_out[13] = b;
    for (int i = 12; i >= 0; i--) begin
      b = b ^ gray_q[i];
      binary_out[i] = b;
    end
  end
endmodule : capture_receiver_model

// >>> verification/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        ref_clk, reset_n, wr_en, rd_en, calibration_reset_n, pc;
  logic        divider_sync_reset, phase_slip, clock_was_stopped;
  logic        over_range_a_in, over_range_b_in, over_range_a_out;
  logic        over_range_b_out, output_sample_clock, outputs_oe;
  logic        cmos_mode, low_drive_current, dll_slow_range;
  logic        dll_locked, calibrating;
  logic [7:0]  addr, wr_data, rd_data;
  logic [1:0]  clock_ratio_select_pin, power_state_select_pin;
  logic [13:0] sample_a_in, sample_b_in, data_a_out, data_b_out, rx_bin;
  logic [13:0] corner [5] = '{14'h0000, 14'h0001, 14'h2000, 14'h3FFE,
                              14'h3FFF};
  logic [7:0]  ovr [3];
  int          err_total, check_count, cyc, n, tg;
  adc_clock_power_output_format #(.CAL_CYCLES(20), .RELOCK_SAMPLES(8))
  dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .clock_ratio_select_pin(clock_ratio_select_pin),
    .power_state_select_pin(power_state_select_pin),
    .calibration_reset_n(calibration_reset_n),
    .divider_sync_reset(divider_sync_reset), .phase_slip(phase_slip),
    .clock_was_stopped(clock_was_stopped), .sample_a_in(sample_a_in),
    .sample_b_in(sample_b_in), .over_range_a_in(over_range_a_in),
    .over_range_b_in(over_range_b_in), .data_a_out(data_a_out),
    .data_b_out(data_b_out), .over_range_a_out(over_range_a_out),
    .over_range_b_out(over_range_b_out),
    .output_sample_clock(output_sample_clock), .outputs_oe(outputs_oe),
    .cmos_mode(cmos_mode), .low_drive_current(low_drive_current),
    .dll_slow_range(dll_slow_range), .dll_locked(dll_locked),
    .calibrating(calibrating));
  capture_receiver_model rx_u (.ref_clk(ref_clk),
    .output_sample_clock(output_sample_clock), .outputs_oe(outputs_oe),
    .data_in(data_a_out), .binary_out(rx_bin));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask : rd_chk
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  // Bounded wait for lock (1) or end of calibration (0)
  task automatic wait_until(input bit lock);
    n = 0;
    while ((lock ? dll_locked !== 1'b1 : calibrating !== 1'b0) && n < 90)
    begin
      wait_cyc(1);
      n++;
    end
  endtask : wait_until
  task automatic toggles(input int k);
    tg = 0;
    repeat (k) begin
      pc = output_sample_clock;
      wait_cyc(1);
      if (output_sample_clock !== pc) tg++;
    end
  endtask : toggles
  function automatic logic [13:0] enc(input logic [13:0] ob, input int f);
    case (f)
      1: return ob ^ (ob >> 1);
      2: return ob;
      default: return {~ob[13], ob[12:0]};
    endcase
  endfunction : enc
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Ceiling well above the fewer than one thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {reset_n, wr_en, rd_en, divider_sync_reset, phase_slip} = 5'h00;
    {clock_was_stopped, over_range_a_in, over_range_b_in} = 3'h0;
    {addr, wr_data, sample_a_in, sample_b_in} = '0;
    calibration_reset_n = 1'b1;
    clock_ratio_select_pin = 2'd1;
    power_state_select_pin = 2'd0;
    void'($urandom(32'h6037B465));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_cyc(3);
    `CHK(calibrating, 1'b1)
    `CHK(data_a_out, 14'h0CCC)
    wait_until(0);
    wait_cyc(12);
    `CHK(data_a_out, 14'h2000)
    `CHK({cmos_mode, low_drive_current}, 2'b00)
    rd_chk(8'h76, 8'h01);
    foreach (corner[i]) rd_chk(8'h70 + 8'(i % 4), 8'h00);
    rd_chk(8'h55, 8'h00);
    for (int p = 0; p < 4; p++) begin
      @(posedge ref_clk);
      power_state_select_pin <= 2'(p);
      wait_cyc(4);
      `CHK(outputs_oe, p == 0)
    end
    ovr = '{8'h81, 8'h82, 8'h80};
    power_state_select_pin <= 2'd2;
    foreach (ovr[i]) begin
      wr(8'h71, ovr[i]);
      wait_cyc(4);
      `CHK(outputs_oe, i == 2)
    end
    wr(8'h71, 8'h00);
    power_state_select_pin <= 2'd0;
    for (int p = 0; p < 4; p++) begin
      @(posedge ref_clk);
      clock_ratio_select_pin <= 2'(p);
      wait_cyc(6);
      toggles(16);
      `CHK(tg, p == 0 ? 8 : p == 2 ? 4 : 16)
    end
    ovr = '{8'h82, 8'h80, 8'h81};
    clock_ratio_select_pin <= 2'd0;
    foreach (ovr[i]) begin
      wr(8'h70, ovr[i]);
      wait_cyc(6);
      toggles(16);
      `CHK(tg, i == 0 ? 4 : i == 1 ? 16 : 8)
    end
    phase_slip <= 1'b1;
    toggles(16);
    `CHK(tg, 0)
    phase_slip <= 1'b0;
    clock_ratio_select_pin <= 2'd1;
    @(posedge ref_clk);
    calibration_reset_n <= 1'b0;
    wait_cyc(1);
    toggles(2);
    `CHK(output_sample_clock, 1'b0)
    `CHK(tg, 0)
    @(posedge ref_clk);
    calibration_reset_n <= 1'b1;
    wait_cyc(3);
    `CHK(data_a_out, 14'h0CCC)
    wait_until(0);
    wr(8'h70, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(8'h73, 8'(f));
      for (int j = 0; j < 8; j++) begin
        @(posedge ref_clk);
        sample_a_in <= j < 5 ? corner[j] : 14'($urandom);
        sample_b_in <= 14'($urandom);
        over_range_a_in <= j[0];
        over_range_b_in <= 1'($urandom);
        wait_cyc(13);
        `CHK(data_a_out, enc(sample_a_in, f))
        `CHK(data_b_out, enc(sample_b_in, f))
        `CHK(over_range_a_out, j[0])
        `CHK(over_range_b_out, over_range_b_in)
        if (f == 1) `CHK(rx_bin, sample_a_in)
      end
    end
    wr(8'h73, 8'h02);
    sample_a_in <= 14'h0000;
    wait_cyc(12);
    @(posedge ref_clk);
    sample_a_in <= 14'h3FFF;
    n = 0;
    while (data_a_out !== 14'h3FFF && n < 30) begin
      wait_cyc(1);
      n++;
    end
    `CHK(n, 10)
    for (int m = 0; m < 4; m++) begin
      wr(8'h73, 8'(m * 16));
      wait_cyc(2);
      `CHK({low_drive_current, cmos_mode}, 2'(m))
    end
    wr(8'h72, 8'h01);
    wait_until(1);
    `CHK(n >= 8 && dll_locked === 1'b1, 1'b1)
    `CHK(dll_slow_range, 1'b1)
    wr(8'h70, 8'h81);
    wait_cyc(3);
    `CHK(dll_locked, 1'b0)
    wr(8'h70, 8'h80);
    wait_until(1);
    `CHK(n >= 8 && dll_locked === 1'b1, 1'b1)
    wr(8'h71, 8'h82);
    clock_was_stopped <= 1'b1;
    wait_cyc(4);
    `CHK(outputs_oe, 1'b0)
    wr(8'h71, 8'h80);
    clock_was_stopped <= 1'b0;
    wait_cyc(2);
    `CHK(dll_locked, 1'b0)
    wait_until(1);
    `CHK(n >= 6 && dll_locked === 1'b1, 1'b1)
    wr(8'h72, 8'h00);
    wait_cyc(4);
    `CHK(dll_locked, 1'b0)
    test_done();
  end
endmodule : tb_top
bind adc_clock_power_output_format adc_ctrl_monitor #(.DATA_W(DATA_W))
mon_u (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .clock_ratio_select_pin(clock_ratio_select_pin),
  .power_state_select_pin(power_state_select_pin),
  .calibration_reset_n(calibration_reset_n), .data_a_out(data_a_out),
  .data_b_out(data_b_out), .over_range_a_out(over_range_a_out),
  .output_sample_clock(output_sample_clock), .outputs_oe(outputs_oe),
  .cmos_mode(cmos_mode), .dll_slow_range(dll_slow_range),
  .dll_locked(dll_locked), .calibrating(calibrating));
